//--- modem_pkg.sv
// shared constants and types of the radio modem link control
package modem_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000;
  localparam int unsigned HOLD_STEP_MS = 100;
  localparam int unsigned SLEEP_STEP_MS = 10;
  localparam int unsigned AWAKE_MS_WIDE = 10;
  localparam int unsigned AWAKE_MS_NARROW = 13;
  localparam int unsigned BYTE_TIME_NS_NARROW = 1667000;
  localparam int unsigned BYTE_TIME_NS_WIDE = 833000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned BYTE_CYC_NARROW = BYTE_TIME_NS_NARROW / CLK_PERIOD_NS;
  localparam int unsigned BYTE_CYC_WIDE = BYTE_TIME_NS_WIDE / CLK_PERIOD_NS;
  localparam logic [7:0] HOLD_FOREVER = 8'hFF;
  localparam logic [7:0] SLEEP_MAX = 8'hF0;
  localparam logic [7:0] NET_CODE_DEFAULT = 8'h01;
  localparam logic [7:0] IDLE_DELAY_DEFAULT_MS = 8'h0A;
  localparam logic [7:0] RSSI_THRESHOLD = 8'h64;
  localparam logic [2:0] CHAN_DEFAULT = 3'h1;
  localparam logic [2:0] BAUD_DEFAULT = 3'h3;
  localparam logic [1:0] PARITY_DEFAULT = 2'h0;
  localparam logic [1:0] POWER_HIGH = 2'h2;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  typedef enum logic [1:0] {PS_AWAKE, PS_SLEEP, PS_HOLD, PS_ACTIVE} pwr_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_LISTEN, TX_SEND} tx_state_t;
endpackage

//--- byte_fifo.sv
// small synchronous fifo with valid and ready on both sides
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;
  fifo_state_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = mem[st_reg.rd];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage has no reset: contents only matter once counted
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr] <= in_data;
    end
  end
endmodule

//--- radio_modem_link_control.sv
// control logic of the radio modem: power cycle, filter, channel, tx gate
// Behaviour
// - hold-awake interval counts in 100 ms ticks
// - a valid radio packet leaves the sleep cycle and holds awake
// - replies during hold-awake use the short preamble
// - on hold-awake expiry the sleep and wake cycle resumes
// - hold-awake 255 keeps device and serial always active, short preamble
// - a repeater computes its own hold-awake and ignores the setting
// - byte time is 1.667 ms narrow and 0.833 ms wide spacing
// - drop radio messages with a foreign network code; default code 1
// - with no channel enabled, operate on channel 1
// - two or three enabled channels turn on multi-channel agility
// - listen-before-transmit sends only below -100 dBm averaged level
// - broadcast mode forwards every message, ignoring addresses; the network code is still checked
// - broadcast network supports exactly one repeater
// - power choice only in the 869.400-869.650 MHz band, else auto
// - serial port runs without any flow control
// - wait serial idle delay after last byte before sending; default 10 ms
// - serial rate selectable 1200 to 38400 bps, default 9600
// - parity none, even or odd; default none
// - during sleep ignore serial input, wake only on radio
// - awake slot lasts 10 ms wide, 13 ms narrow, not configurable
// - sleep interval 1 to 240 in 10 ms steps; 0 means always active
module radio_modem_link_control
  import modem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic narrow_spacing,
  input wire logic [7:0] hold_awake_interval,
  input wire logic [7:0] sleep_interval,
  input wire logic is_repeater,
  input wire logic [7:0] repeater_hold,
  input wire logic [7:0] net_code,
  input wire logic broadcast_mode,
  input wire logic [7:0] own_address,
  input wire logic [2:0] channel_enable,
  input wire logic listen_before_transmit,
  input wire logic [7:0] avg_level_neg_dbm,
  input wire logic power_band_selectable,
  input wire logic [1:0] power_choice,
  input wire logic [1:0] power_auto,
  input wire logic [7:0] serial_idle_delay,
  input wire logic [2:0] baud_select,
  input wire logic [1:0] parity_select,
  input wire logic rx_pkt_valid,
  input wire logic [7:0] rx_pkt_net_code,
  input wire logic [7:0] rx_pkt_target,
  input wire logic ser_in_valid,
  input wire logic [7:0] ser_in_data,
  output logic ser_in_ready,
  output logic radio_tx_valid,
  input wire logic radio_tx_ready,
  output logic [7:0] radio_tx_data,
  output logic radio_tx_start,
  output logic long_preamble,
  output logic rx_deliver,
  output logic rx_enabled,
  output logic serial_enabled,
  output logic [2:0] active_channels,
  output logic multi_channel_agility,
  output logic [1:0] power_level,
  output logic [2:0] baud_code,
  output logic [1:0] parity_code,
  output logic flow_control_en,
  output logic [21:0] byte_time_cycles
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [14:0] ms_div;
    logic ms_tick;
    pwr_state_t pwr;
    logic [14:0] pwr_ms;
    tx_state_t tx;
    logic [7:0] idle_ms;
    logic tx_start;
    logic deliver;
    logic long_pre;
    logic [2:0] chans;
    logic agility;
    logic [1:0] power;
  } ctl_state_t;
  ctl_state_t st_reg, st_next;

  localparam logic [14:0] MS_LAST = 15'(MS_TICK_CYCLES - 1);
  localparam logic [21:0] BYTE_NARROW = 22'(BYTE_CYC_NARROW);
  localparam logic [21:0] BYTE_WIDE = 22'(BYTE_CYC_WIDE);

  // serial pin synchroniser
  logic [1:0] ser_v_sync;
  logic [7:0] ser_d_s1, ser_d_s2;
  logic pkt_ok;
  logic fifo_in_valid, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] hold_eff;
  logic always_on;
  logic ser_accept;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] count_bits(input logic [2:0] v);
    count_bits = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction

  // a held interval of 254 x 100 ms needs the full 15 bits
  function automatic logic [14:0] ms_of(input logic [7:0] n,
                                        input logic [7:0] step);
    ms_of = 15'(n) * 15'(step);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_v_sync <= '0;
      ser_d_s1 <= '0;
      ser_d_s2 <= '0;
    end else if (ce) begin
      ser_v_sync <= {ser_v_sync[0], ser_in_valid};
      ser_d_s1 <= ser_in_data;
      ser_d_s2 <= ser_d_s1;
    end
  end

  // repeater timing replaces the user hold value
  assign hold_eff = is_repeater ? repeater_hold : hold_awake_interval;
  assign always_on = (sleep_interval == 8'h00) ||
                     (hold_eff == HOLD_FOREVER);
  assign pkt_ok = rx_pkt_valid && rx_enabled &&
                  (rx_pkt_net_code == net_code) &&
                  (broadcast_mode || rx_pkt_target == own_address);
  // no flow control: a byte arriving with the buffer full is dropped
  assign serial_enabled = (st_reg.pwr != PS_SLEEP);
  assign ser_accept = ser_v_sync[1] && serial_enabled;
  assign fifo_in_valid = ser_accept;
  assign ser_in_ready = serial_enabled;
  assign flow_control_en = 1'b0;
  assign rx_enabled = 1'b1; // radio stays listening to wake from sleep
  assign fifo_out_ready = (st_reg.tx == TX_SEND) && radio_tx_ready;
  assign radio_tx_valid = (st_reg.tx == TX_SEND) && fifo_out_valid;
  assign radio_tx_data = fifo_out_data;
  assign radio_tx_start = st_reg.tx_start;
  assign long_preamble = st_reg.long_pre;
  assign rx_deliver = st_reg.deliver;
  assign active_channels = st_reg.chans;
  assign multi_channel_agility = st_reg.agility;
  assign power_level = st_reg.power;
  assign baud_code = baud_select;
  assign parity_code = parity_select;
  assign byte_time_cycles = narrow_spacing ? BYTE_NARROW : BYTE_WIDE;

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(),
    .in_data(ser_d_s2),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tx_start = 1'b0;
    st_next.deliver = pkt_ok;
    // common millisecond tick
    st_next.ms_tick = 1'b0;
    if (st_reg.ms_div == MS_LAST) begin
      st_next.ms_div = '0;
      st_next.ms_tick = 1'b1;
    end else begin
      st_next.ms_div = st_reg.ms_div + 1'b1;
    end

    if (channel_enable == 3'h0) begin
      st_next.chans = CHAN_DEFAULT;
    end else begin
      st_next.chans = channel_enable;
    end
    st_next.agility = (count_bits(channel_enable) >= 2'd2);
    st_next.power = power_band_selectable ? power_choice
                                          : power_auto;

    // power saving cycle
    case (st_reg.pwr)
      PS_AWAKE: begin
        if (always_on) begin
          st_next.pwr = PS_ACTIVE;
        end else if (pkt_ok) begin
          st_next.pwr = PS_HOLD;
          st_next.pwr_ms = ms_of(hold_eff, 8'(HOLD_STEP_MS));
        end else if (st_reg.ms_tick) begin
          if (st_reg.pwr_ms <= 15'h0001) begin
            st_next.pwr = PS_SLEEP;
            st_next.pwr_ms = ms_of(sleep_interval, 8'(SLEEP_STEP_MS));
          end else begin
            st_next.pwr_ms = st_reg.pwr_ms - 1'b1;
          end
        end
      end
      PS_SLEEP: begin
        if (always_on) begin
          st_next.pwr = PS_ACTIVE;
        end else if (pkt_ok) begin
          st_next.pwr = PS_HOLD;
          st_next.pwr_ms = ms_of(hold_eff, 8'(HOLD_STEP_MS));
        end else if (st_reg.ms_tick) begin
          if (st_reg.pwr_ms <= 15'h0001) begin
            st_next.pwr = PS_AWAKE;
            st_next.pwr_ms = narrow_spacing ? 15'(AWAKE_MS_NARROW)
                                            : 15'(AWAKE_MS_WIDE);
          end else begin
            st_next.pwr_ms = st_reg.pwr_ms - 1'b1;
          end
        end
      end
      PS_HOLD: begin
        if (always_on) begin
          st_next.pwr = PS_ACTIVE;
        end else if (pkt_ok) begin
          st_next.pwr_ms = ms_of(hold_eff, 8'(HOLD_STEP_MS));
        end else if (st_reg.ms_tick) begin
          if (st_reg.pwr_ms <= 15'h0001) begin
            st_next.pwr = PS_AWAKE;
            st_next.pwr_ms = narrow_spacing ? 15'(AWAKE_MS_NARROW)
                                            : 15'(AWAKE_MS_WIDE);
          end else begin
            st_next.pwr_ms = st_reg.pwr_ms - 1'b1;
          end
        end
      end
      default: begin
        if (!always_on) begin
          st_next.pwr = PS_AWAKE;
          st_next.pwr_ms = narrow_spacing ? 15'(AWAKE_MS_NARROW)
                                          : 15'(AWAKE_MS_WIDE);
        end
      end
    endcase

    // transmit path: idle delay, then listen gate, then drain
    if (ser_accept) begin
      st_next.idle_ms = serial_idle_delay;
    end
    case (st_reg.tx)
      TX_IDLE: begin
        if (ser_accept) begin
          st_next.tx = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (!ser_accept && st_reg.ms_tick) begin
          if (st_reg.idle_ms <= 8'h01) begin
            st_next.tx = TX_LISTEN;
          end else begin
            st_next.idle_ms = st_reg.idle_ms - 1'b1;
          end
        end
      end
      TX_LISTEN: begin
        // level is in -dBm, so a larger figure means a quieter channel
        if (!listen_before_transmit ||
            avg_level_neg_dbm > RSSI_THRESHOLD) begin
          st_next.tx = TX_SEND;
          st_next.tx_start = 1'b1;
          // short preamble while held awake or when never sleeping
          st_next.long_pre = (st_reg.pwr != PS_HOLD) &&
                             (sleep_interval != 8'h00) &&
                             (hold_eff != HOLD_FOREVER);
        end
      end
      default: begin
        if (!fifo_out_valid && !ser_accept) begin
          st_next.tx = TX_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{ms_div: '0, ms_tick: 1'b0, pwr: PS_ACTIVE,
                  pwr_ms: '0, tx: TX_IDLE, idle_ms: IDLE_DELAY_DEFAULT_MS,
                  tx_start: 1'b0, deliver: 1'b0, long_pre: 1'b0,
                  chans: CHAN_DEFAULT, agility: 1'b0, power: POWER_HIGH};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

//--- link_control_properties.sv
// port-level assertions of the radio modem link control
module link_control_properties
  import modem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic narrow_spacing,
  input wire logic [7:0] hold_awake_interval,
  input wire logic [7:0] sleep_interval,
  input wire logic [7:0] net_code,
  input wire logic broadcast_mode,
  input wire logic [7:0] own_address,
  input wire logic [2:0] channel_enable,
  input wire logic listen_before_transmit,
  input wire logic [7:0] avg_level_neg_dbm,
  input wire logic power_band_selectable,
  input wire logic [1:0] power_choice,
  input wire logic [1:0] power_auto,
  input wire logic [2:0] baud_select,
  input wire logic [1:0] parity_select,
  input wire logic rx_pkt_valid,
  input wire logic [7:0] rx_pkt_net_code,
  input wire logic [7:0] rx_pkt_target,
  input wire logic ser_in_ready,
  input wire logic radio_tx_start,
  input wire logic long_preamble,
  input wire logic rx_deliver,
  input wire logic serial_enabled,
  input wire logic [2:0] active_channels,
  input wire logic multi_channel_agility,
  input wire logic [1:0] power_level,
  input wire logic [2:0] baud_code,
  input wire logic [1:0] parity_code,
  input wire logic flow_control_en,
  input wire logic [21:0] byte_time_cycles
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------
  // checks
  // ------
  a_accept_packet: assert property (
    rx_pkt_valid && rx_pkt_net_code == net_code
    && (broadcast_mode || rx_pkt_target == own_address) |=> rx_deliver)
    else $error("accepted packet not delivered");
  a_drop_foreign: assert property (
    rx_pkt_valid && rx_pkt_net_code != net_code |=> !rx_deliver)
    else $error("foreign network packet delivered");
  a_byte_time: assert property (
    byte_time_cycles == (narrow_spacing ? BYTE_CYC_NARROW : BYTE_CYC_WIDE))
    else $error("byte time wrong for spacing");
  a_no_flow: assert property (!flow_control_en)
    else $error("flow control enabled");
  a_pass_format: assert property (
    baud_code == baud_select && parity_code == parity_select)
    else $error("serial format not passed on");
  a_chan_default: assert property (
    $past(rst_n) && channel_enable == 3'h0 && $past(channel_enable) == 3'h0
    |-> active_channels == 3'h1)
    else $error("empty channel set not on channel one");
  a_agility_on: assert property (
    $past(rst_n) && $countones(channel_enable) > 1
    && $countones($past(channel_enable)) > 1 |-> multi_channel_agility)
    else $error("agility off with several channels");
  a_power_pick: assert property (
    $past(rst_n) && $stable(power_band_selectable) && $stable(power_choice)
    && $stable(power_auto) |-> power_level ==
    (power_band_selectable ? power_choice : power_auto))
    else $error("power level source wrong");
  a_always_on: assert property (
    $past(rst_n) && hold_awake_interval == 8'hFF
    && $stable(hold_awake_interval) |-> serial_enabled && ser_in_ready)
    else $error("serial side off while held forever");
  a_short_preamble: assert property (
    radio_tx_start && sleep_interval == 8'h00 |=> !long_preamble)
    else $error("long preamble without power cycling");
  a_lbt_gate: assert property (
    radio_tx_start && $past(listen_before_transmit)
    |-> $past(avg_level_neg_dbm) > 8'h64)
    else $error("transmit started on a busy channel");
endmodule

bind radio_modem_link_control link_control_properties u_props (
  .clk, .rst_n, .narrow_spacing, .hold_awake_interval, .sleep_interval,
  .net_code, .broadcast_mode, .own_address, .channel_enable,
  .listen_before_transmit, .avg_level_neg_dbm, .power_band_selectable,
  .power_choice, .power_auto, .baud_select, .parity_select, .rx_pkt_valid,
  .rx_pkt_net_code, .rx_pkt_target, .ser_in_ready, .radio_tx_start,
  .long_preamble, .rx_deliver, .serial_enabled, .active_channels,
  .multi_channel_agility, .power_level, .baud_code, .parity_code,
  .flow_control_en, .byte_time_cycles
);

//--- dte_model.sv
// serial terminal model: pushes bytes without looking at any ready
module dte_model (
  input wire logic clk,
  output logic ser_in_valid,
  output logic [7:0] ser_in_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_in_valid = 1'b0;
    ser_in_data = 8'h00;
  end
  // released line shows the inverse so stale data never looks valid
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    ser_in_valid = 1'b1;
    ser_in_data = b;
    @(negedge clk);
    ser_in_valid = 1'b0;
    ser_in_data = ~b;
    @(negedge clk);
  endtask
endmodule

//--- radio_modem_link_control_bench.sv
// self-checking bench of the radio modem link control
module radio_modem_link_control_bench;
  import modem_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, narrow_spacing, is_repeater, broadcast_mode;
  logic listen_before_transmit, power_band_selectable, rx_pkt_valid;
  logic ser_in_valid, ser_in_ready, radio_tx_valid, radio_tx_ready;
  logic radio_tx_start, long_preamble, rx_deliver, rx_enabled;
  logic serial_enabled, multi_channel_agility, flow_control_en;
  logic [7:0] hold_awake_interval, sleep_interval, repeater_hold, net_code;
  logic [7:0] own_address, avg_level_neg_dbm, serial_idle_delay;
  logic [7:0] rx_pkt_net_code, rx_pkt_target, ser_in_data, radio_tx_data;
  logic [2:0] channel_enable, active_channels, baud_select, baud_code;
  logic [1:0] power_choice, power_auto, parity_select, parity_code;
  logic [1:0] power_level;
  logic [21:0] byte_time_cycles;
  logic [31:0] seed, r;
  logic [7:0] q[$];
  int bad_count, num_checks, n, hits;

  radio_modem_link_control u_dut (
    .clk, .rst_n, .ce(1'b1), .narrow_spacing, .hold_awake_interval,
    .sleep_interval, .is_repeater, .repeater_hold, .net_code,
    .broadcast_mode, .own_address, .channel_enable, .listen_before_transmit,
    .avg_level_neg_dbm, .power_band_selectable, .power_choice, .power_auto,
    .serial_idle_delay, .baud_select, .parity_select, .rx_pkt_valid,
    .rx_pkt_net_code, .rx_pkt_target, .ser_in_valid, .ser_in_data,
    .ser_in_ready, .radio_tx_valid, .radio_tx_ready, .radio_tx_data,
    .radio_tx_start, .long_preamble, .rx_deliver, .rx_enabled,
    .serial_enabled, .active_channels, .multi_channel_agility, .power_level,
    .baud_code, .parity_code, .flow_control_en, .byte_time_cycles
  );
  dte_model u_dte (.clk, .ser_in_valid, .ser_in_data);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ------
  // helpers
  // ------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // the bound of 60000 cycles sits 10000 above the two ms ticks of the longest wait
  task automatic wait_start();
    n = 0;
    while (radio_tx_start !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 60000) begin
        bad_count++;
        finish_test();
      end
    end
  endtask
  task automatic drain(input logic exp_long);
    check(long_preamble, exp_long);
    radio_tx_ready = 1'b1;
    for (int i = 0; i < 20 && radio_tx_valid === 1'b1; i++) begin
      check(radio_tx_data, q.pop_front());
      @(negedge clk);
    end
    radio_tx_ready = 1'b0;
    check(q.size(), 0);
  endtask
  // ------
  // sequence
  // ------
  initial begin
    rst_n = 1'b0;
    narrow_spacing = 1'b0;
    hold_awake_interval = 8'hFF;
    sleep_interval = 8'h00;
    is_repeater = 1'b0;
    repeater_hold = 8'h0F;
    net_code = 8'h01;
    broadcast_mode = 1'b0;
    own_address = 8'h05;
    channel_enable = 3'h0;
    listen_before_transmit = 1'b0;
    avg_level_neg_dbm = 8'h64;
    power_band_selectable = 1'b0;
    power_choice = 2'h0;
    power_auto = 2'h0;
    serial_idle_delay = 8'h01;
    baud_select = 3'h3;
    parity_select = 2'h0;
    rx_pkt_valid = 1'b0;
    rx_pkt_net_code = 8'h00;
    rx_pkt_target = 8'h00;
    radio_tx_ready = 1'b0;
    bad_count = 0;
    num_checks = 0;
    seed = 32'h8;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      narrow_spacing = r[0];
      baud_select = 3'(i);
      parity_select = 2'(i % 3);
      channel_enable = 3'(i);
      power_band_selectable = r[1];
      power_choice = 2'(i % 3);
      power_auto = 2'((i + 1) % 3);
      repeater_hold = r[15:8];
      repeat (2) @(negedge clk);
      check(byte_time_cycles, r[0] ? 41675 : 20825);
      check({baud_code, parity_code}, {3'(i), 2'(i % 3)});
      check(active_channels, i == 0 ? 1 : i);
      check(multi_channel_agility, $countones(i) > 1);
      check(power_level, r[1] ? i % 3 : (i + 1) % 3);
      check({flow_control_en, rx_enabled, serial_enabled}, 3'h3);
      check(ser_in_ready, 1);
    end
    for (int i = 0; i < 24; i++) begin
      r = xs();
      broadcast_mode = r[0];
      rx_pkt_net_code = r[1] ? net_code : r[15:8];
      rx_pkt_target = r[2] ? own_address : r[23:16];
      rx_pkt_valid = 1'b1;
      @(negedge clk);
      rx_pkt_valid = 1'b0;
      hits = int'(rx_deliver);
      @(negedge clk);
      hits += int'(rx_deliver);
      check(hits, rx_pkt_net_code == net_code && (broadcast_mode ||
        rx_pkt_target == own_address));
    end
    listen_before_transmit = 1'b1;
    for (int i = 0; i < 3; i++) begin
      r = xs();
      q.push_back(r[7:0]);
      u_dte.send(r[7:0]);
    end
    hits = 0;
    // listen is reached within one ms tick, the rest of the window is gated
    repeat (25500) begin
      @(negedge clk);
      hits += int'(radio_tx_start);
    end
    check(hits, 0);
    avg_level_neg_dbm = 8'h78;
    wait_start();
    drain(1'b0);
    // power cycling: a reply sent from the awake slot uses the long preamble
    listen_before_transmit = 1'b0;
    avg_level_neg_dbm = 8'h10;
    serial_idle_delay = 8'h02;
    sleep_interval = 8'h01;
    hold_awake_interval = 8'h01;
    for (int i = 0; i < 2; i++) begin
      r = xs();
      q.push_back(r[7:0]);
      u_dte.send(r[7:0]);
    end
    wait_start();
    check(n >= 25000 && n <= 75010, 1);
    drain(1'b1);
    // a valid packet holds the device awake, so the reply goes out short
    broadcast_mode = 1'b1;
    rx_pkt_net_code = net_code;
    rx_pkt_valid = 1'b1;
    @(negedge clk);
    rx_pkt_valid = 1'b0;
    serial_idle_delay = 8'h01;
    check(rx_deliver, 1);
    r = xs();
    q.push_back(r[7:0]);
    u_dte.send(r[7:0]);
    wait_start();
    check(serial_enabled, 1);
    drain(1'b0);
    finish_test();
  end
endmodule
